// ---- core/lbt_pkg.sv ----
// Constants, types and selector encodings for the logic block tile.
// Assumes a single system clock; configuration bits arrive as plain ports.
package lbt_pkg;

   localparam int unsigned NUM_CELLS   = 8;
   localparam int unsigned NUM_GLOBAL_BUFFER    = 8;
   localparam int unsigned TABLE_IN    = 4;
   localparam int unsigned TABLE_DEPTH = 16;
   localparam int unsigned GLUT_MAX    = 4;
   localparam int unsigned SEL_W       = 3;
   localparam logic        WAKE_VALUE  = 1'h0;

   typedef enum logic [1:0] {
      LBT_SRC_ROUTE,
      LBT_SRC_GLOBAL_BUFFER,
      LBT_SRC_OFF
   } lbt_src_e;

   typedef struct packed {
      logic [TABLE_DEPTH-1:0] table_bits;
      logic                   use_reg;
      logic                   use_carry;
   } lbt_cell_cfg_s;

   typedef struct packed {
      lbt_src_e             clk_src;
      logic [SEL_W-1:0]     clk_sel;
      lbt_src_e             en_src;
      logic [SEL_W-1:0]     en_sel;
      lbt_src_e             sr_src;
      logic [SEL_W-1:0]     sr_sel;
      logic                 sr_async;
      logic                 sr_value;
      logic [NUM_GLOBAL_BUFFER-1:0]  glut_mask;
   } lbt_tile_cfg_s;

endpackage : lbt_pkg

// ---- core/lbt_tile.sv ----
// Logic block tile: eight cells with tables, flip-flops and carry chain.
// Assumes CLK_I is the 20 MHz system clock; the tile clock selection is
// modelled as a qualifier of CLK_I, since a real clock mux is not
// synthesised in a single-clock design.
`timescale 1ns/1ps
`default_nettype none

module lbt_tile #(
   parameter int unsigned CELLS = lbt_pkg::NUM_CELLS,
   parameter int unsigned GBUFS = lbt_pkg::NUM_GLOBAL_BUFFER
) (
   // Clock and reset.
   input  wire logic                              CLK_I,
   input  wire logic                              RST_N_I,
   // Configuration state.
   input  wire logic                              CONFIG_ACTIVE_I,
   input  wire lbt_pkg::lbt_tile_cfg_s            TILE_CFG_I,
   input  wire lbt_pkg::lbt_cell_cfg_s [CELLS-1:0] CELL_CFG_I,
   // Global network and pins.
   input  wire logic [GBUFS-1:0]                  GLOBAL_INPUT_PIN_I,
   input  wire logic [GBUFS-1:0]                  GLOBAL_CLK_USE_I,
   input  wire logic [GBUFS-1:0]                  GPIO_OUT_I,
   input  wire logic [GBUFS-1:0]                  GPIO_OE_I,
   output logic [GBUFS-1:0]                       GPIO_IN_O,
   output logic [GBUFS-1:0]                       GPIO_OUT_O,
   output logic [GBUFS-1:0]                       GPIO_OE_O,
   output logic                                   GLOBAL_FLOAT_CONTROL_O,
   // Routing-side control inputs.
   input  wire logic                              ROUTE_CLK_I,
   input  wire logic                              ROUTE_EN_I,
   input  wire logic                              ROUTE_SR_I,
   // Cell data.
   input  wire logic [CELLS-1:0][lbt_pkg::TABLE_IN-1:0] CELL_IN_I,
   input  wire logic [CELLS-1:0][lbt_pkg::TABLE_IN-1:0] CELL_GSEL_I,
   input  wire logic                              CARRY_CHAIN_IN_I,
   output logic                                   CARRY_CHAIN_OUT_O,
   output logic [CELLS-1:0]                       CELL_OUT_O,
   output logic                                   GLUT_CFG_ERR_O
);

   ////////////////////////////////////////////////////////////////////////
   // Global buffers and dual-use pins.

   logic [GBUFS-1:0] global_buffer;
   logic             glut_ok;
   logic [3:0]       glut_count;

   // A pin not claimed by the clock network behaves as plain I/O.
   assign global_buffer = GLOBAL_INPUT_PIN_I & GLOBAL_CLK_USE_I;
   assign GPIO_IN_O     = GLOBAL_INPUT_PIN_I & ~GLOBAL_CLK_USE_I;
   assign GPIO_OUT_O    = GPIO_OUT_I & ~GLOBAL_CLK_USE_I;
   // Floating during configuration overrides every output enable.
   assign GPIO_OE_O     = CONFIG_ACTIVE_I ? '0
                          : (GPIO_OE_I & ~GLOBAL_CLK_USE_I);
   assign GLOBAL_FLOAT_CONTROL_O = CONFIG_ACTIVE_I;

   always_comb begin
      glut_count = '0;
      for (int i = 0; i < GBUFS; i++) begin
         glut_count = glut_count + {3'h0, TILE_CFG_I.glut_mask[i]};
      end
   end
   assign glut_ok        = (glut_count <= 4'(lbt_pkg::GLUT_MAX));
   assign GLUT_CFG_ERR_O = ~glut_ok;

   ////////////////////////////////////////////////////////////////////////
   // Shared tile controls.

   logic tile_clk_q;
   logic tile_en;
   logic tile_sr;
   logic clk_prev_reg;
   logic clk_sel_lvl;

   always_comb begin
      unique case (TILE_CFG_I.clk_src)
         lbt_pkg::LBT_SRC_GLOBAL_BUFFER:  clk_sel_lvl =
            global_buffer[TILE_CFG_I.clk_sel];
         lbt_pkg::LBT_SRC_ROUTE: clk_sel_lvl = ROUTE_CLK_I;
         default:                clk_sel_lvl = 1'h0;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         clk_prev_reg <= 1'h0;
      end else begin
         clk_prev_reg <= clk_sel_lvl;
      end
   end
   // The tile advances on a rising edge of the selected clock.
   assign tile_clk_q = clk_sel_lvl & ~clk_prev_reg;

   always_comb begin
      unique case (TILE_CFG_I.en_src)
         lbt_pkg::LBT_SRC_GLOBAL_BUFFER:  tile_en =
            TILE_CFG_I.en_sel[0] & global_buffer[TILE_CFG_I.en_sel];
         lbt_pkg::LBT_SRC_ROUTE: tile_en = ROUTE_EN_I;
         default:                tile_en = 1'h1;
      endcase
   end

   always_comb begin
      unique case (TILE_CFG_I.sr_src)
         lbt_pkg::LBT_SRC_GLOBAL_BUFFER:  tile_sr =
            ~TILE_CFG_I.sr_sel[0] & global_buffer[TILE_CFG_I.sr_sel];
         lbt_pkg::LBT_SRC_ROUTE: tile_sr = ROUTE_SR_I;
         default:                tile_sr = 1'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Logic cells and carry chain.

   logic [CELLS:0]   carry;
   logic [CELLS-1:0] table_out;
   logic [CELLS-1:0] ff_reg;
   logic [CELLS-1:0] async_sr;

   assign carry[0]          = CARRY_CHAIN_IN_I;
   assign CARRY_CHAIN_OUT_O = carry[CELLS];

   genvar c;
   generate
      for (c = 0; c < CELLS; c++) begin : g_cell
         logic [lbt_pkg::TABLE_IN-1:0] tin;
         logic                         d_next;

         // Table inputs may take global buffer 0 or GBUFS-1, picked by the input bit, if permitted.
         for (genvar k = 0; k < lbt_pkg::TABLE_IN; k++) begin : g_in
            assign tin[k] = (CELL_GSEL_I[c][k] && glut_ok &&
                             TILE_CFG_I.glut_mask[
                                CELL_IN_I[c][k] ? GBUFS-1 : 0])
                            ? global_buffer[CELL_IN_I[c][k] ? GBUFS-1 : 0]
                            : CELL_IN_I[c][k];
         end

         assign table_out[c] = CELL_CFG_I[c].table_bits[tin];

         // Carry: majority of the two middle inputs and incoming carry.
         assign carry[c+1] = CELL_CFG_I[c].use_carry
            ? ((tin[1] & tin[2]) | (carry[c] & (tin[1] | tin[2])))
            : carry[c];

         assign async_sr[c] = tile_sr & TILE_CFG_I.sr_async;

         always_comb begin
            d_next = ff_reg[c];
            if (tile_clk_q && tile_en) begin
               d_next = table_out[c];
            end
            if (tile_clk_q && tile_sr && !TILE_CFG_I.sr_async) begin
               d_next = TILE_CFG_I.sr_value;
            end
            if (async_sr[c]) begin
               d_next = TILE_CFG_I.sr_value;
            end
            if (CONFIG_ACTIVE_I) begin
               d_next = lbt_pkg::WAKE_VALUE;
            end
         end

         always_ff @(posedge CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
               ff_reg[c] <= lbt_pkg::WAKE_VALUE;
            end else begin
               ff_reg[c] <= d_next;
            end
         end

         assign CELL_OUT_O[c] = CELL_CFG_I[c].use_reg ? ff_reg[c]
                                                     : table_out[c];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   a_config_wake: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CONFIG_ACTIVE_I |=> (ff_reg == '0))
      else $error("Flip-flops not cleared by configuration.");
   a_float_cfg: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      CONFIG_ACTIVE_I |-> (GPIO_OE_O == '0) && GLOBAL_FLOAT_CONTROL_O)
      else $error("I/O driven during configuration.");
   a_hold_no_en: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (!CONFIG_ACTIVE_I && !tile_en && !tile_sr) |=> $stable(ff_reg))
      else $error("Flip-flop changed without enable.");
   a_unused_sr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (TILE_CFG_I.sr_src == lbt_pkg::LBT_SRC_OFF) |-> !tile_sr)
      else $error("Set/reset active while unused.");
   a_even_sr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (TILE_CFG_I.sr_src == lbt_pkg::LBT_SRC_GLOBAL_BUFFER &&
       TILE_CFG_I.sr_sel[0]) |-> !tile_sr)
      else $error("Odd buffer drove set/reset.");
   a_odd_en: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (TILE_CFG_I.en_src == lbt_pkg::LBT_SRC_GLOBAL_BUFFER &&
       !TILE_CFG_I.en_sel[0]) |-> !tile_en)
      else $error("Even buffer drove clock enable.");
   a_load_table: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (!CONFIG_ACTIVE_I && tile_clk_q && tile_en && !tile_sr)
      |=> (ff_reg == $past(table_out)))
      else $error("Flip-flop did not load table output.");
   a_async_sr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (!CONFIG_ACTIVE_I && tile_sr && TILE_CFG_I.sr_async)
      |=> (ff_reg == {CELLS{$past(TILE_CFG_I.sr_value)}}))
      else $error("Asynchronous set/reset not applied.");
   a_glut_limit: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (glut_count > 4'(lbt_pkg::GLUT_MAX)) |-> GLUT_CFG_ERR_O)
      else $error("Too many global table inputs accepted.");

   c_load: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
      tile_clk_q && tile_en && !CONFIG_ACTIVE_I);
   c_sync_sr: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
      tile_clk_q && tile_sr && !TILE_CFG_I.sr_async);
   c_carry_out: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
      CARRY_CHAIN_OUT_O && !CARRY_CHAIN_IN_I);
   c_config: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
      $fell(CONFIG_ACTIVE_I));

endmodule : lbt_tile

`default_nettype wire

// ---- verification/lbt_fabric_model.sv ----
// Fabric model: makes one slow tile clock pulse for each request.
// Assumes requests last one CLK_I cycle and come at least four apart.
`timescale 1ns/1ps
`default_nettype none
module lbt_fabric_model (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic req_i,
   output logic      tclk_o
);
   logic [1:0] cnt_reg;
   // The slow clock stands low between pulses and is high for two cycles.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= 2'h0;
      end else if (req_i) begin
         cnt_reg <= 2'h2;
      end else if (cnt_reg != 2'h0) begin
         cnt_reg <= cnt_reg - 2'h1;
      end
   end
   assign tclk_o = (cnt_reg != 2'h0);
endmodule : lbt_fabric_model
`default_nettype wire

// ---- verification/lbt_tile_tb_top.sv ----
// Testbench for the logic block tile: tables, registers, controls, carry.
// Assumes lbt_fabric_model supplies the slow tile clock pulses.
`timescale 1ns/1ps
`default_nettype none
module lbt_tile_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, cfg = 1'b1, req = 1'b0, rclk_on = 1'b1;
   logic ren = 1'b0, rsr = 1'b0, cin = 1'b0, tclk, float_o, cout, gerr;
   logic [7:0] gbase = '0, gclk = '0, guse = '0, goe = '1;
   logic [7:0] gin_o, goe_o, cell_o, q;
   logic [7:0][3:0] ins = '0, gsel = '0;
   lbt_pkg::lbt_tile_cfg_s tc;
   lbt_pkg::lbt_cell_cfg_s [7:0] cc;
   int n_fail = 0, comparisons = 0;

   lbt_fabric_model u_fab (.clk_i(clk), .rst_n_i(rst_n), .req_i(req),
      .tclk_o(tclk));
   lbt_tile u_dut (
      .CLK_I(clk), .RST_N_I(rst_n), .CONFIG_ACTIVE_I(cfg), .TILE_CFG_I(tc),
      .CELL_CFG_I(cc), .GLOBAL_INPUT_PIN_I(gbase | ({8{tclk}} & gclk)),
      .GLOBAL_CLK_USE_I(guse), .GPIO_OUT_I(8'h5A), .GPIO_OE_I(goe),
      .GPIO_IN_O(gin_o), .GPIO_OUT_O(), .GPIO_OE_O(goe_o),
      .GLOBAL_FLOAT_CONTROL_O(float_o), .ROUTE_CLK_I(tclk & rclk_on),
      .ROUTE_EN_I(ren), .ROUTE_SR_I(rsr), .CELL_IN_I(ins),
      .CELL_GSEL_I(gsel), .CARRY_CHAIN_IN_I(cin), .CARRY_CHAIN_OUT_O(cout),
      .CELL_OUT_O(cell_o), .GLUT_CFG_ERR_O(gerr));

   initial forever #25 clk = ~clk;

   function automatic logic [15:0] tbl(input int c);
      return 16'h6A5C ^ (16'(c) * 16'h0123);
   endfunction : tbl
   function automatic logic [7:0] expt(input int i);
      logic [15:0] t;
      logic [7:0] e;
      for (int c = 0; c < 8; c++) begin
         t = tbl(c);
         e[c] = t[i];
      end
      return e;
   endfunction : expt
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   // One tile clock event, then time for the result to settle.
   task automatic ev();
      req = 1'b1;
      cyc(1);
      req = 1'b0;
      cyc(4);
   endtask : ev
   task automatic setall(input int i);
      for (int c = 0; c < 8; c++) ins[c] = 4'(i);
   endtask : setall
   task automatic results();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   initial begin
      tc = '{clk_src: lbt_pkg::LBT_SRC_ROUTE, en_src: lbt_pkg::LBT_SRC_OFF,
             sr_src: lbt_pkg::LBT_SRC_OFF, default: '0};
      for (int c = 0; c < 8; c++) cc[c] = '{tbl(c), 1'b1, 1'b1};
      cyc(20);
      rst_n = 1'b1;
      setall(15);
      ev();
      chk("float", 8'(float_o), 8'h01);
      chk("gpio_oe", goe_o, 8'h00);
      chk("cfg_hold", cell_o, 8'h00);
      cfg = 1'b0;
      cyc(1);
      chk("wake", cell_o, 8'h00);
      ev();
      q = expt(15);
      chk("load", cell_o, q);
      for (int c = 0; c < 8; c++) cc[c].use_reg = 1'b0;
      for (int i = 0; i < 16; i++) begin
         setall(i);
         cyc(1);
         chk("table", cell_o, expt(i));
      end
      $display("config and table tests done");
      for (int c = 0; c < 8; c++) cc[c].use_reg = 1'b1;
      tc.clk_src = lbt_pkg::LBT_SRC_GLOBAL_BUFFER;
      rclk_on = 1'b0;
      for (int k = 0; k < 8; k++) begin
         tc.clk_sel = 3'(k);
         guse = 8'h01 << k;
         gclk = guse;
         setall(k);
         ev();
         q = expt(k);
         chk("global_buffer_clk", cell_o, q);
         setall(k + 8);
         cyc(3);
         chk("hold", cell_o, q);
      end
      tc.clk_src = lbt_pkg::LBT_SRC_ROUTE;
      rclk_on = 1'b1;
      guse = 8'h00;
      gclk = 8'h00;
      tc.en_src = lbt_pkg::LBT_SRC_ROUTE;
      setall(3);
      ev();
      chk("en_off", cell_o, q);
      ren = 1'b1;
      ev();
      q = expt(3);
      chk("en_on", cell_o, q);
      tc.en_src = lbt_pkg::LBT_SRC_GLOBAL_BUFFER;
      for (int s = 0; s < 8; s++) begin
         tc.en_sel = 3'(s);
         gbase = 8'h01 << s;
         guse = 8'h01 << s;
         setall(s);
         ev();
         if (s % 2 == 1) q = expt(s);
         chk("global_buffer_en", cell_o, q);
      end
      $display("clock and enable tests done");
      tc.en_src = lbt_pkg::LBT_SRC_OFF;
      gbase = 8'h00;
      guse = 8'h00;
      tc.sr_src = lbt_pkg::LBT_SRC_ROUTE;
      tc.sr_value = 1'b1;
      rsr = 1'b1;
      cyc(3);
      chk("sync_wait", cell_o, q);
      ev();
      chk("sync_sr", cell_o, 8'hFF);
      tc.sr_value = 1'b0;
      tc.sr_async = 1'b1;
      cyc(2);
      chk("async_sr", cell_o, 8'h00);
      rsr = 1'b0;
      tc.sr_value = 1'b1;
      for (int s = 0; s < 8; s++) begin
         tc.sr_src = lbt_pkg::LBT_SRC_OFF;
         setall(s + 8);
         ev();
         q = expt(s + 8);
         chk("sr_unused", cell_o, q);
         tc.sr_src = lbt_pkg::LBT_SRC_GLOBAL_BUFFER;
         tc.sr_sel = 3'(s);
         gbase = 8'h01 << s;
         guse = 8'h01 << s;
         cyc(3);
         if (s % 2 == 0) q = 8'hFF;
         chk("global_buffer_sr", cell_o, q);
         gbase = 8'h00;
         guse = 8'h00;
      end
      $display("set/reset tests done");
      for (int c = 0; c < 8; c++) ins[c] = 4'h2;
      cin = 1'b1;
      cyc(1);
      chk("carry_prop", 8'(cout), 8'h01);
      ins[0] = 4'h0;
      ins[5] = 4'h6;
      cyc(1);
      chk("carry_order", 8'(cout), 8'h01);
      ins[5] = 4'h2;
      cyc(1);
      chk("carry_kill", 8'(cout), 8'h00);
      cc[0].use_carry = 1'b0;
      cyc(1);
      chk("carry_skip", 8'(cout), 8'h01);
      tc.glut_mask = 8'h1F;
      cyc(1);
      chk("glut_err", 8'(gerr), 8'h01);
      tc.glut_mask = 8'hF0;
      cyc(1);
      chk("glut_ok", 8'(gerr), 8'h00);
      guse = 8'h0F;
      gbase = 8'hAA;
      cyc(1);
      chk("gpio_in", gin_o, 8'hA0);
      chk("gpio_oe", goe_o, 8'hF0);
      for (int c = 0; c < 8; c++) cc[c].use_reg = 1'b0;
      setall(15);
      gsel = '1;
      cyc(1);
      chk("glut_sub", cell_o, expt(0));
      tc.glut_mask = 8'h1F;
      cyc(1);
      chk("glut_block", cell_o, expt(15));
      $display("carry, global and pin tests done");
      results();
   end

   initial begin
      cyc(3000);
      n_fail++;
      results();
   end
endmodule : lbt_tile_tb_top
`default_nettype wire
